// ---- logic/jisp_defines.svh ----
// constants for the test-port programming sequencer
`ifndef JISP_DEFINES_SVH
`define JISP_DEFINES_SVH
`define JISP_IR_W        4
`define JISP_IR_UNLOCK   4'h9
`define JISP_IR_ERASE    4'hA
`define JISP_IR_PROGRAM  4'hB
`define JISP_IR_VERIFY   4'hC
`define JISP_IR_BYPASS   4'hF
`define JISP_IR_CAPTURE  4'h1
`define JISP_ERASED_BIT  1'b1
`define JISP_ROWS        32
`define JISP_ADDR_W      5
`define JISP_ROW_W       16
`endif

// ---- logic/jisp_pkg.sv ----
// types for the test-port programming sequencer
package jisp_pkg;
    typedef enum logic [3:0] {
        TAP_RESET  = 4'h0,
        TAP_IDLE   = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SH_DR  = 4'h4,
        TAP_EX1_DR = 4'h5,
        TAP_PA_DR  = 4'h6,
        TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'hA,
        TAP_SH_IR  = 4'hB,
        TAP_EX1_IR = 4'hC,
        TAP_PA_IR  = 4'hD,
        TAP_EX2_IR = 4'hE,
        TAP_UPD_IR = 4'hF
    } jisp_tap_e;

    typedef enum logic {
        SYS_IDLE = 1'b0,
        SYS_READ = 1'b1
    } jisp_sys_e;
endpackage

// ---- logic/jisp_row_mem.sv ----
// configuration row array with whole-array erase and registered read
`timescale 1ns/1ps
`include "jisp_defines.svh"
module jisp_row_mem
    import jisp_pkg::*;
#(
    parameter int ROWS   = `JISP_ROWS,
    parameter int ADDR_W = `JISP_ADDR_W,
    parameter int ROW_W  = `JISP_ROW_W
)(
    input  wire logic              clk_sys,
    input  wire logic              eraseAll,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [ROW_W-1:0]  wrData,
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [ROW_W-1:0]  rdData
);
    logic [ROW_W-1:0] rows [ROWS];

    // erase clears every row in one edge, not one row at a time
    always_ff @(posedge clk_sys)
    begin
        if (eraseAll)
        begin
            for (int i = 0; i < ROWS; i++)
                rows[i] <= {ROW_W{`JISP_ERASED_BIT}};
        end
        else if (wrEn)
            rows[wrAddr] <= wrData;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rdEn)
            rdData <= rows[rdAddr];
    end
endmodule

// ---- logic/jisp_sequencer.sv ----
// test access port and in-system programming sequencer for the row array
`timescale 1ns/1ps
`include "jisp_defines.svh"
module jisp_sequencer
    import jisp_pkg::*;
#(
    parameter int ROWS   = `JISP_ROWS,
    parameter int ADDR_W = `JISP_ADDR_W,
    parameter int ROW_W  = `JISP_ROW_W,
    parameter int PINS   = 8
)(
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    input  wire logic            tck,
    input  wire logic            tms,
    input  wire logic            tdi,
    output logic                 tdoOut,
    output logic                 tdoOe,
    input  wire logic [PINS-1:0] logicOut,
    input  wire logic [PINS-1:0] verifyPinState,
    output logic      [PINS-1:0] pinOut,
    output logic                 verifyMode
);
    localparam int DR_W = ADDR_W + ROW_W;

    function automatic jisp_tap_e tapNext(input jisp_tap_e s,
                                          input logic m);
        unique case (s)
            TAP_RESET:  tapNext = m ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   tapNext = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tapNext = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tapNext = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tapNext = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tapNext = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  tapNext = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tapNext = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tapNext = m ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: tapNext = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tapNext = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tapNext = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  tapNext = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tapNext = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction

    function automatic logic isOperation(input logic [`JISP_IR_W-1:0] c);
        isOperation = (c == `JISP_IR_ERASE) || (c == `JISP_IR_PROGRAM)
                   || (c == `JISP_IR_VERIFY);
    endfunction

    // test-clock domain
    logic                  rstSync1_r, tckRstN_r;
    jisp_tap_e             tap_r;
    logic [`JISP_IR_W-1:0] ir_r, irSr_r, reqOp_r;
    logic [DR_W-1:0]       dr_r;
    logic                  byp_r, unlock_r, verifyOn_r;
    logic                  reqTgl_r, ackS1_r, ackS2_r;
    logic [ADDR_W-1:0]     reqAddr_r;
    logic [ROW_W-1:0]      reqData_r;
    logic                  ispSel, opIdle;
    // system-clock domain
    logic                  reqS1_r, reqS2_r, reqS3_r, ackTgl_r;
    logic                  verS1_r, verS2_r;
    jisp_sys_e             sys_r;
    logic [ROW_W-1:0]      rdHold_r, rdData;
    logic                  reqEdge, memErase, memWr, memRd;

    // power-up reset stands in for a test reset pin
    always_ff @(posedge tck)
    begin
        rstSync1_r <= rstn;
        tckRstN_r  <= rstSync1_r;
    end

    assign ispSel = (ir_r == `JISP_IR_UNLOCK) || isOperation(ir_r);
    assign opIdle = (ackS2_r == reqTgl_r);

    always_ff @(posedge tck)
    begin
        if (!tckRstN_r)
            tap_r <= TAP_RESET;
        else
            tap_r <= tapNext(tap_r, tms);
    end

    always_ff @(posedge tck)
    begin
        if (!tckRstN_r || tap_r == TAP_RESET)
            irSr_r <= `JISP_IR_CAPTURE;
        else if (tap_r == TAP_CAP_IR)
            irSr_r <= `JISP_IR_CAPTURE;
        else if (tap_r == TAP_SH_IR)
            irSr_r <= {tdi, irSr_r[`JISP_IR_W-1:1]};
    end

    always_ff @(posedge tck)
    begin
        if (!tckRstN_r || tap_r == TAP_RESET)
            ir_r <= `JISP_IR_BYPASS;
        else if (tap_r == TAP_UPD_IR)
            ir_r <= irSr_r;
    end

    // unlock lasts for the session, ended only by a test-logic reset
    always_ff @(posedge tck)
    begin
        if (!tckRstN_r || tap_r == TAP_RESET)
            unlock_r <= 1'b0;
        else if (tap_r == TAP_UPD_IR && irSr_r == `JISP_IR_UNLOCK)
            unlock_r <= 1'b1;
    end

    always_ff @(posedge tck)
    begin
        if (!tckRstN_r)
            verifyOn_r <= 1'b0;
        else
            verifyOn_r <= unlock_r && (ir_r == `JISP_IR_VERIFY);
    end

    // address in the low bits, shifted in first; row data above it
    always_ff @(posedge tck)
    begin
        if (!tckRstN_r)
            dr_r <= '0;
        else if (tap_r == TAP_CAP_DR && ir_r == `JISP_IR_VERIFY
                 && unlock_r && opIdle)
            dr_r <= {rdHold_r, dr_r[ADDR_W-1:0]};
        else if (tap_r == TAP_SH_DR && ispSel)
            dr_r <= {tdi, dr_r[DR_W-1:1]};
    end

    always_ff @(posedge tck)
    begin
        if (!tckRstN_r || tap_r == TAP_CAP_DR)
            byp_r <= 1'b0;
        else if (tap_r == TAP_SH_DR)
            byp_r <= tdi;
    end

    // a new operation is ignored until the previous one has been acknowledged
    always_ff @(posedge tck)
    begin
        if (!tckRstN_r)
        begin
            reqTgl_r  <= 1'b0;
            reqOp_r   <= `JISP_IR_BYPASS;
            reqAddr_r <= '0;
            reqData_r <= '0;
        end
        else if (tap_r == TAP_UPD_DR && unlock_r && isOperation(ir_r)
                 && opIdle)
        begin
            reqTgl_r  <= ~reqTgl_r;
            reqOp_r   <= ir_r;
            reqAddr_r <= dr_r[ADDR_W-1:0];
            reqData_r <= dr_r[DR_W-1:ADDR_W];
        end
    end

    always_ff @(posedge tck)
    begin
        ackS1_r <= ackTgl_r;
        ackS2_r <= ackS1_r;
    end

    // output side turns on the falling edge so the far end samples a stable bit
    always_ff @(negedge tck)
    begin
        if (!tckRstN_r)
        begin
            tdoOut <= 1'b0;
            tdoOe  <= 1'b0;
        end
        else
        begin
            tdoOe  <= (tap_r == TAP_SH_DR) || (tap_r == TAP_SH_IR);
            if (tap_r == TAP_SH_IR)
                tdoOut <= irSr_r[0];
            else if (tap_r == TAP_SH_DR)
                tdoOut <= ispSel ? dr_r[0] : byp_r;
            else
                tdoOut <= 1'b0;
        end
    end

    // system side: request toggle synchronised, words stable behind it
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            reqS1_r <= 1'b0;
            reqS2_r <= 1'b0;
            reqS3_r <= 1'b0;
        end
        else
        begin
            reqS1_r <= reqTgl_r;
            reqS2_r <= reqS1_r;
            reqS3_r <= reqS2_r;
        end
    end

    assign reqEdge  = (sys_r == SYS_IDLE) && (reqS2_r != reqS3_r);
    assign memErase = reqEdge && (reqOp_r == `JISP_IR_ERASE);
    assign memWr    = reqEdge && (reqOp_r == `JISP_IR_PROGRAM);
    assign memRd    = reqEdge && (reqOp_r == `JISP_IR_VERIFY);

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            sys_r    <= SYS_IDLE;
            ackTgl_r <= 1'b0;
            rdHold_r <= '0;
        end
        else
        begin
            unique case (sys_r)
                SYS_IDLE:
                begin
                    if (memRd)
                        sys_r <= SYS_READ;
                    else if (reqEdge)
                        ackTgl_r <= ~ackTgl_r;
                end
                SYS_READ:
                begin
                    rdHold_r <= rdData;
                    ackTgl_r <= ~ackTgl_r;
                    sys_r    <= SYS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            verS1_r <= 1'b0;
            verS2_r <= 1'b0;
        end
        else
        begin
            verS1_r <= verifyOn_r;
            verS2_r <= verS1_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            pinOut     <= '0;
            verifyMode <= 1'b0;
        end
        else
        begin
            verifyMode <= verS2_r;
            pinOut     <= verS2_r ? verifyPinState : logicOut;
        end
    end

    // the array has no write path other than the test port
    jisp_row_mem #(
        .ROWS   (ROWS),
        .ADDR_W (ADDR_W),
        .ROW_W  (ROW_W)
    ) rowMem (
        .clk_sys  (clk_sys),
        .eraseAll (memErase),
        .wrEn     (memWr),
        .wrAddr   (reqAddr_r),
        .wrData   (reqData_r),
        .rdEn     (memRd),
        .rdAddr   (reqAddr_r),
        .rdData   (rdData)
    );
endmodule

// ---- tb/jisp_seq_checker.sv ----
// port assertions for the programming sequencer
`timescale 1ns/1ps
module jisp_seq_checker
    import jisp_pkg::*;
#(
    parameter int PINS = 8
)(
    input wire logic            clk_sys,
    input wire logic            rstn,
    input wire logic            tck,
    input wire logic            tms,
    input wire logic            tdoOut,
    input wire logic            tdoOe,
    input wire logic [PINS-1:0] logicOut,
    input wire logic [PINS-1:0] verifyPinState,
    input wire logic [PINS-1:0] pinOut,
    input wire logic            verifyMode
);
    // five high mode bits reach test-logic-reset from any state
    sequence s_reset_walk;
        tms [*5];
    endsequence
    sequence s_shift_stay;
        tdoOe && !tms;
    endsequence
    property p_pins_verify;
        @(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && verifyMode |-> pinOut == $past(verifyPinState);
    endproperty
    a_pins_verify: assert property (p_pins_verify)
        else $error("pins not at user verify state");
    property p_pins_user;
        @(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && !verifyMode |-> pinOut == $past(logicOut);
    endproperty
    a_pins_user: assert property (p_pins_user)
        else $error("pins not at logic values");
    // edges never coincide, so a change seen with tck high came from a rise
    property p_tdo_fall;
        @(posedge clk_sys) disable iff (!rstn)
        tdoOut != $past(tdoOut) |-> !tck;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall)
        else $error("tdo moved outside falling edge");
    property p_oe_fall;
        @(posedge clk_sys) disable iff (!rstn)
        tdoOe != $past(tdoOe) |-> !tck;
    endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("tdo enable moved outside falling edge");
    property p_oe_out_zero;
        @(posedge clk_sys) disable iff (!rstn)
        !tdoOe |-> !tdoOut;
    endproperty
    a_oe_out_zero: assert property (p_oe_out_zero)
        else $error("tdo data while undriven");
    property p_shift_stay;
        @(posedge tck) disable iff (!rstn)
        s_shift_stay |=> tdoOe;
    endproperty
    a_shift_stay: assert property (p_shift_stay)
        else $error("shift left with mode low");
    property p_shift_exit;
        @(posedge tck) disable iff (!rstn)
        tdoOe && tms |=> !tdoOe;
    endproperty
    a_shift_exit: assert property (p_shift_exit)
        else $error("tdo driven after shift exit");
    property p_tlr_clear;
        @(posedge tck) disable iff (!rstn)
        s_reset_walk |-> ##4 !verifyMode && !tdoOe;
    endproperty
    a_tlr_clear: assert property (p_tlr_clear)
        else $error("session kept after test reset");
endmodule
bind jisp_sequencer jisp_seq_checker #(.PINS(PINS)) u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .tck(tck), .tms(tms),
    .tdoOut(tdoOut), .tdoOe(tdoOe), .logicOut(logicOut),
    .verifyPinState(verifyPinState), .pinOut(pinOut),
    .verifyMode(verifyMode));

// ---- tb/jisp_prog_model.sv ----
// programmer model: all array access goes over these four wires
`timescale 1ns/1ps
module jisp_prog_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // one clock period; inputs move only while the clock is low
    task automatic step(input logic m, input logic dIn, output logic q);
        tms = m;
        tdi = dIn;
        #62.5 tck = 1'b1;
        q = tdo;
        #62.5 tck = 1'b0;
    endtask
    // data in toggles when unused so a stale bit cannot pass
    task automatic run(input logic m, input int n);
        logic q;
        repeat (n) step(m, ~tdi, q);
    endtask
    task automatic scan(input logic isIr, input int n,
                        input logic [20:0] dIn, output logic [20:0] dOut);
        logic q;
        dOut = '0;
        run(1'b1, isIr ? 2 : 1);
        run(1'b0, 2);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, dIn[i], q);
            dOut[i] = q;
        end
        run(1'b1, 1);
        run(1'b0, 1);
    endtask
endmodule

// ---- tb/jisp_sequencer_tb_top.sv ----
// self-checking bench for the programming sequencer
`timescale 1ns/1ps
`include "jisp_defines.svh"
module jisp_sequencer_tb_top
    import jisp_pkg::*;
;
    logic        clk_sys, rstn, tck, tms, tdi, tdoOut, tdoOe, verifyMode;
    logic [7:0]  pinOut;
    logic [7:0]  logicOut = 8'h5A;
    logic [7:0]  verifyPinState = 8'hC3;
    int          num_errors = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [20:0] d;
    // row: programmed data above the row address
    logic [20:0] rows [4] = '{{16'h1234, 5'h00}, {16'hA5C3, 5'h1F},
                              {16'h0000, 5'h01}, {16'hFFFE, 5'h10}};
    wire         tdoLine = tdoOe ? tdoOut : 1'b1; // pulled up when undriven

    jisp_sequencer dut (.clk_sys(clk_sys), .rstn(rstn), .tck(tck),
        .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe),
        .logicOut(logicOut), .verifyPinState(verifyPinState),
        .pinOut(pinOut), .verifyMode(verifyMode));
    jisp_prog_model prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoLine));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            num_errors++;
            results();
        end
    end
    task automatic check(input string name, input logic [20:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic ir(input logic [3:0] c);
        prog.scan(1'b1, 4, {17'h0, c}, d);
        check("ir capture", d, {17'h0, `JISP_IR_CAPTURE});
    endtask
    // verify: launch the read, then capture and shift it out
    task automatic rd(input logic [4:0] a);
        ir(`JISP_IR_VERIFY);
        prog.scan(1'b0, 21, {16'h0, a}, d);
        check("verify pins", {13'h0, pinOut}, {13'h0, verifyPinState});
        check("verify mode", {20'h0, verifyMode}, 21'h1);
        prog.run(1'b0, 16);
        prog.scan(1'b0, 21, {16'h0, a}, d);
        prog.run(1'b0, 16);
    endtask
    initial
    begin
        rstn = 1'b0;
        fork
            repeat (12) @(posedge clk_sys);
            prog.run(1'b1, 3);
        join
        #2;
        check("reset pins", {13'h0, pinOut}, 21'h0);
        check("reset oe", {20'h0, tdoOe}, 21'h0);
        rstn = 1'b1;
        prog.run(1'b1, 5);
        prog.run(1'b0, 1);
        ir(`JISP_IR_UNLOCK);
        check("user pins", {13'h0, pinOut}, {13'h0, logicOut});
        foreach (rows[i])
        begin
            // user values move so the pin mux cannot pass on a constant
            @(posedge clk_sys) #2 logicOut = rows[i][12:5];
            ir(`JISP_IR_PROGRAM);
            prog.scan(1'b0, 21, rows[i], d);
            check("user pins", {13'h0, pinOut}, {13'h0, logicOut});
            check("user mode", {20'h0, verifyMode}, 21'h0);
            prog.run(1'b0, 16);
            rd(rows[i][4:0]);
            check("row data", d >> 5, rows[i] >> 5);
            check("row addr", d & 21'h1F, rows[i] & 21'h1F);
        end
        ir(`JISP_IR_ERASE);
        prog.scan(1'b0, 21, 21'h0, d);
        prog.run(1'b0, 16);
        foreach (rows[i])
        begin
            rd(rows[i][4:0]);
            check("erased", d >> 5, 21'hFFFF);
        end
        // test reset ends the session, so this program must be ignored
        prog.run(1'b1, 5);
        prog.run(1'b0, 1);
        // one-bit bypass: a zero from capture, then the bits shifted in
        prog.scan(1'b0, 4, 21'h5, d);
        check("bypass", d, 21'hA);
        ir(`JISP_IR_PROGRAM);
        prog.scan(1'b0, 21, rows[0], d);
        prog.run(1'b0, 16);
        ir(`JISP_IR_UNLOCK);
        rd(rows[0][4:0]);
        check("locked row", d >> 5, 21'hFFFF);
        results();
    end
endmodule
